//--- inc/mmsv_regs.svh
// Address map, stack and vector constants for the memory map block
`ifndef MMSV_REGS_SVH
`define MMSV_REGS_SVH
`define MMSV_RAM_LO      16'h0060
`define MMSV_RAM_HI      16'h035f
`define MMSV_RAM_BYTES   768
`define MMSV_PZ_HI       16'h00ff
`define MMSV_SP_RESET    16'h00ff
`define MMSV_ROM_LO      16'hfe10
`define MMSV_ROM_HI      16'hfeff
`define MMSV_ROM_BYTES   240
`define MMSV_VEC_TXD     16'hffd2
`define MMSV_VEC_RXD     16'hffd4
`define MMSV_VEC_T2OVF   16'hffde
`define MMSV_VEC_T2CH0   16'hffe2
`define MMSV_VEC_T1OVF   16'hffe4
`define MMSV_VEC_RESET   16'hfffe
`define MMSV_INT_BYTES   3'h5
`define MMSV_CALL_BYTES  3'h2
`endif

//--- inc/mmsv_pkg.sv
// Types for the memory map block
`default_nettype none
package mmsv_pkg;
  typedef enum logic [2:0] {
    MMSV_IDLE  = 3'b000,
    MMSV_PUSH  = 3'b001,
    MMSV_VECHI = 3'b011,
    MMSV_VECLO = 3'b010,
    MMSV_PULL  = 3'b110
  } mmsv_state_e;
  typedef enum logic [1:0] {
    MMSV_SEL_NONE = 2'h0,
    MMSV_SEL_RAM  = 2'h1,
    MMSV_SEL_ROM  = 2'h2,
    MMSV_SEL_VEC  = 2'h3
  } mmsv_sel_e;
endpackage
`default_nettype wire

//--- logic/mmsv_memory_map.sv
// Memory map decode, stack pointer engine and vector selection
// Function
// R1: RAM region of 768 bytes decoded at 0x0060..0x035F.
// R2: Stack pointer is 16 bits, covering the full address space.
// R3: Stack pointer resets to 0x00FF.
// R4: 160 bytes of that RAM lie in page zero.
// R5: Interrupt entry pushes exactly five bytes.
// R6: High index byte is not stacked on interrupt.
// R7: Subroutine call pushes a two-byte return address.
// R8: Stack pointer decrements on push, increments on pull.
// R9: 0xFE10..0xFEFF maps to 240-byte monitor ROM.
// R10: Serial transmit vector at 0xFFD2 high, 0xFFD3 low.
// R11: Serial receive vector at 0xFFD4 high, 0xFFD5 low.
// R12: Second timer overflow vector at 0xFFDE high, 0xFFDF low.
// R13: Second timer channel 0 vector at 0xFFE2 high, 0xFFE3 low.
// R14: First timer overflow vector at 0xFFE4 high, 0xFFE5 low.
// R15: Pending sources served highest vector address first, reset highest.
`timescale 1ns/1ps
`default_nettype none
`include "mmsv_regs.svh"
module mmsv_memory_map (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Decode request from the core
  input  wire logic [15:0] busAddr,
  output logic             selRam,
  output logic             selPageZero,
  output logic             selRom,
  output logic             selVector,
  // Stack requests: push or pull one byte, or start a frame
  input  wire logic        pushReq,
  input  wire logic        pullReq,
  input  wire logic        callReq,
  input  wire logic        intReq,
  input  wire logic [15:0] spLoad,
  input  wire logic        spLoadEn,
  output logic [15:0]      stackPtr,
  output logic [15:0]      stackAddr,
  output logic             stackWrite,
  output logic             stackRead,
  output logic [2:0]       frameByte,
  output logic             frameBusy,
  // Pending interrupt sources
  input  wire logic        resetPend,
  input  wire logic        serTxPend,
  input  wire logic        serRxPend,
  input  wire logic        tmr2OvfPend,
  input  wire logic        tmr2Ch0Pend,
  input  wire logic        tmr1OvfPend,
  output logic [15:0]      vecAddr,
  output logic             vecValid
);

  // One decode shared by every registered select
  function automatic mmsv_pkg::mmsv_sel_e decodeAddr(input logic [15:0] a);
    if (a >= `MMSV_RAM_LO && a <= `MMSV_RAM_HI)
      decodeAddr = mmsv_pkg::MMSV_SEL_RAM; // see R1
    else if (a >= `MMSV_ROM_LO && a <= `MMSV_ROM_HI)
      decodeAddr = mmsv_pkg::MMSV_SEL_ROM; // see R9
    else if (a >= `MMSV_VEC_TXD)
      decodeAddr = mmsv_pkg::MMSV_SEL_VEC;
    else
      decodeAddr = mmsv_pkg::MMSV_SEL_NONE;
  endfunction

  mmsv_pkg::mmsv_state_e stateFf, nxtStateFf;
  logic [15:0] spFf, nxtSpFf;
  logic [2:0]  leftFf, nxtLeftFf;
  logic [15:0] stackAddrFf, nxtStackAddrFf;
  logic        stackWriteFf, nxtStackWriteFf;
  logic        stackReadFf, nxtStackReadFf;
  logic        frameBusyFf, nxtFrameBusyFf;
  logic        selRamFf, selPzFf, selRomFf, selVecFf;
  logic        nxtSelRamFf, nxtSelPzFf, nxtSelRomFf, nxtSelVecFf;
  logic [15:0] vecAddrFf, nxtVecAddrFf;
  logic        vecValidFf, nxtVecValidFf;
  logic [15:0] vecPick;
  logic        anyPend;
  mmsv_pkg::mmsv_sel_e curSel;

  // Highest vector address wins; reset above all
  always_comb begin
    anyPend = 1'b1;
    if (resetPend) vecPick = `MMSV_VEC_RESET;          // see R15
    else if (tmr1OvfPend) vecPick = `MMSV_VEC_T1OVF;   // see R14
    else if (tmr2Ch0Pend) vecPick = `MMSV_VEC_T2CH0;   // see R13
    else if (tmr2OvfPend) vecPick = `MMSV_VEC_T2OVF;   // see R12
    else if (serRxPend) vecPick = `MMSV_VEC_RXD;       // see R11
    else if (serTxPend) vecPick = `MMSV_VEC_TXD;       // see R10
    else begin
      vecPick = 16'h0000;
      anyPend = 1'b0;
    end
  end

  // Selects lag busAddr by a cycle so every output leaves a flop
  always_comb begin
    curSel      = decodeAddr(busAddr);
    nxtSelRamFf = (curSel == mmsv_pkg::MMSV_SEL_RAM);
    // Page zero RAM is 0x0060..0x00FF, 160 bytes
    nxtSelPzFf  = (curSel == mmsv_pkg::MMSV_SEL_RAM) && (busAddr <= `MMSV_PZ_HI); // see R4
    nxtSelRomFf = (curSel == mmsv_pkg::MMSV_SEL_ROM);
    nxtSelVecFf = (curSel == mmsv_pkg::MMSV_SEL_VEC);
  end

  always_comb begin
    nxtStateFf      = stateFf;
    nxtSpFf         = spFf;
    nxtLeftFf       = leftFf;
    nxtStackAddrFf  = stackAddrFf;
    nxtStackWriteFf = 1'b0;
    nxtStackReadFf  = 1'b0;
    nxtFrameBusyFf  = frameBusyFf;
    nxtVecAddrFf    = vecAddrFf;
    nxtVecValidFf   = 1'b0;
    case (stateFf)
      mmsv_pkg::MMSV_IDLE: begin
        if (intReq) begin
          // Frame is PCL, PCH, X, A, CCR; high index byte left out
          nxtLeftFf      = `MMSV_INT_BYTES; // see R5, R6
          nxtFrameBusyFf = 1'b1;
          nxtVecAddrFf   = vecPick;         // see R15
          nxtStateFf     = mmsv_pkg::MMSV_PUSH;
        end else if (callReq) begin
          nxtLeftFf      = `MMSV_CALL_BYTES; // see R7
          nxtFrameBusyFf = 1'b1;
          nxtVecAddrFf   = 16'h0000;
          nxtStateFf     = mmsv_pkg::MMSV_PUSH;
        end else if (pushReq) begin
          nxtStackAddrFf  = spFf;
          nxtStackWriteFf = 1'b1;
          nxtSpFf         = spFf - 16'h0001; // see R8
        end else if (pullReq) begin
          nxtSpFf         = spFf + 16'h0001; // see R8
          nxtStackAddrFf  = spFf + 16'h0001;
          nxtStackReadFf  = 1'b1;
        end else if (spLoadEn) begin
          nxtSpFf = spLoad; // see R2
        end
      end
      mmsv_pkg::MMSV_PUSH: begin
        // Push writes at SP then decrements
        nxtStackAddrFf  = spFf;
        nxtStackWriteFf = 1'b1;
        nxtSpFf         = spFf - 16'h0001; // see R8
        nxtLeftFf       = leftFf - 3'h1;
        if (leftFf == 3'h1) begin
          if (vecAddrFf != 16'h0000 && anyPend) nxtStateFf = mmsv_pkg::MMSV_VECHI;
          else begin
            nxtStateFf     = mmsv_pkg::MMSV_IDLE;
            nxtFrameBusyFf = 1'b0;
          end
        end
      end
      mmsv_pkg::MMSV_VECHI: begin
        nxtVecValidFf = 1'b1;
        nxtStateFf    = mmsv_pkg::MMSV_VECLO;
      end
      mmsv_pkg::MMSV_VECLO: begin
        // Low byte sits one above the high byte
        nxtVecAddrFf  = vecAddrFf + 16'h0001;
        nxtVecValidFf = 1'b1;
        nxtStateFf    = mmsv_pkg::MMSV_PULL;
      end
      mmsv_pkg::MMSV_PULL: begin
        nxtFrameBusyFf = 1'b0;
        nxtStateFf     = mmsv_pkg::MMSV_IDLE;
      end
      default: begin
        nxtStateFf     = mmsv_pkg::MMSV_IDLE;
        nxtFrameBusyFf = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stateFf      <= mmsv_pkg::MMSV_IDLE;
      spFf         <= `MMSV_SP_RESET; // see R3
      leftFf       <= 3'h0;
      stackAddrFf  <= 16'h0000;
      stackWriteFf <= 1'b0;
      stackReadFf  <= 1'b0;
      frameBusyFf  <= 1'b0;
      vecAddrFf    <= 16'h0000;
      vecValidFf   <= 1'b0;
      selRamFf     <= 1'b0;
      selPzFf      <= 1'b0;
      selRomFf     <= 1'b0;
      selVecFf     <= 1'b0;
    end else begin
      stateFf      <= nxtStateFf;
      spFf         <= nxtSpFf;
      leftFf       <= nxtLeftFf;
      stackAddrFf  <= nxtStackAddrFf;
      stackWriteFf <= nxtStackWriteFf;
      stackReadFf  <= nxtStackReadFf;
      frameBusyFf  <= nxtFrameBusyFf;
      vecAddrFf    <= nxtVecAddrFf;
      vecValidFf   <= nxtVecValidFf;
      selRamFf     <= nxtSelRamFf;
      selPzFf      <= nxtSelPzFf;
      selRomFf     <= nxtSelRomFf;
      selVecFf     <= nxtSelVecFf;
    end
  end

  assign selRam      = selRamFf;
  assign selPageZero = selPzFf;
  assign selRom      = selRomFf;
  assign selVector   = selVecFf;
  assign stackPtr    = spFf;
  assign stackAddr   = stackAddrFf;
  assign stackWrite  = stackWriteFf;
  assign stackRead   = stackReadFf;
  assign frameByte   = leftFf;
  assign frameBusy   = frameBusyFf;
  assign vecAddr     = vecAddrFf;
  assign vecValid    = vecValidFf;

endmodule // mmsv_memory_map
`default_nettype wire

//--- verif/mmsv_checker_assertions.sv
// Port checker for the memory map block
`timescale 1ns/1ps
`default_nettype none
module mmsv_checker (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rst,
  // Requests from the core
  input wire logic        pushReq,
  input wire logic        pullReq,
  input wire logic        callReq,
  input wire logic        intReq,
  input wire logic [15:0] busAddr,
  // Decode and stack outputs
  input wire logic        selRam,
  input wire logic        selPageZero,
  input wire logic        selRom,
  input wire logic [15:0] stackPtr,
  input wire logic [15:0] stackAddr,
  input wire logic        stackWrite,
  input wire logic        stackRead,
  input wire logic [2:0]  frameByte,
  input wire logic        frameBusy,
  input wire logic [15:0] vecAddr,
  input wire logic        vecValid
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_push_dec: assert property (
    pushReq && !intReq && !callReq && !frameBusy |=> stackWrite &&
    stackAddr == $past(stackPtr) && stackPtr == $past(stackPtr) - 16'h0001) else $error("bad push");
  a_pull_inc: assert property (
    pullReq && !pushReq && !intReq && !callReq && !frameBusy |=> stackRead &&
    stackPtr == $past(stackPtr) + 16'h0001 && stackAddr == stackPtr) else $error("bad pull");
  a_int_five: assert property (
    intReq && !frameBusy |=> frameBusy && frameByte == 3'h5 ##1 stackWrite [*5] ##1 !stackWrite)
    else $error("bad interrupt frame");
  a_call_two: assert property (
    callReq && !intReq && !frameBusy |=> frameBusy ##1 stackWrite [*2] ##1 !stackWrite)
    else $error("bad call frame");
  a_sp_reset: assert property ($fell(rst) |-> stackPtr == 16'h00ff)
    else $error("bad stack reset");
  a_ram_sel: assert property (!$past(rst) |-> selRam ==
    ($past(busAddr) >= 16'h0060 && $past(busAddr) <= 16'h035f)) else $error("bad ram select");
  a_rom_sel: assert property (!$past(rst) |-> selRom ==
    ($past(busAddr) >= 16'hfe10 && $past(busAddr) <= 16'hfeff)) else $error("bad rom select");
  a_pz_sel: assert property (!$past(rst) |-> selPageZero ==
    ($past(busAddr) >= 16'h0060 && $past(busAddr) <= 16'h00ff)) else $error("bad page zero select");
  // Low byte must follow the high byte in the very next cycle
  a_vec_pair: assert property ($rose(vecValid) |=> vecValid &&
    vecAddr == $past(vecAddr) + 16'h0001) else $error("bad vector pair");
endmodule // mmsv_checker
bind mmsv_memory_map mmsv_checker u_chk (
  .sys_clk     (sys_clk),
  .rst         (rst),
  .pushReq     (pushReq),
  .pullReq     (pullReq),
  .callReq     (callReq),
  .intReq      (intReq),
  .busAddr     (busAddr),
  .selRam      (selRam),
  .selPageZero (selPageZero),
  .selRom      (selRom),
  .stackPtr    (stackPtr),
  .stackAddr   (stackAddr),
  .stackWrite  (stackWrite),
  .stackRead   (stackRead),
  .frameByte   (frameByte),
  .frameBusy   (frameBusy),
  .vecAddr     (vecAddr),
  .vecValid    (vecValid)
);
`default_nettype wire

//--- verif/mmsv_cpu_model.sv
// Core model issuing stack and frame requests
`timescale 1ns/1ps
`default_nettype none
module mmsv_cpu_model (
  // Clock and command: 1 push, 2 pull, 3 call, 4 interrupt
  input  wire logic       sys_clk,
  input  wire logic       go,
  input  wire logic [2:0] op,
  // Requests, one per command cycle
  output logic            pushReq = 1'h0,
  output logic            pullReq = 1'h0,
  output logic            callReq = 1'h0,
  output logic            intReq  = 1'h0
);
  // Registered so requests change only just after an edge
  always @(posedge sys_clk) begin
    pushReq <= go && op == 3'h1;
    pullReq <= go && op == 3'h2;
    callReq <= go && op == 3'h3;
    intReq  <= go && op == 3'h4;
  end
endmodule // mmsv_cpu_model
`default_nettype wire

//--- verif/mmsv_memory_map_tb.sv
// Self-checking bench for the memory map block
`timescale 1ns/1ps
`default_nettype none
module mmsv_memory_map_tb;
  logic sys_clk = 1'h0, rst = 1'h1, go = 1'h0, spLoadEn = 1'h0;
  logic resetPend = 1'h0, serTxPend = 1'h0, serRxPend = 1'h0;
  logic tmr2OvfPend = 1'h0, tmr2Ch0Pend = 1'h0, tmr1OvfPend = 1'h0;
  logic [2:0] op = 3'h0;
  logic [15:0] busAddr = 16'h0000, spLoad = 16'h0000;
  logic selRam, selPageZero, selRom, selVector, pushReq, pullReq, callReq, intReq;
  logic stackWrite, stackRead, frameBusy, vecValid;
  logic [15:0] stackPtr, stackAddr, vecAddr;
  logic [2:0] frameByte;
  int errTotal = 0;
  int nCompared = 0;
  mmsv_memory_map u_dut (
    .sys_clk     (sys_clk),
    .rst         (rst),
    .busAddr     (busAddr),
    .selRam      (selRam),
    .selPageZero (selPageZero),
    .selRom      (selRom),
    .selVector   (selVector),
    .pushReq     (pushReq),
    .pullReq     (pullReq),
    .callReq     (callReq),
    .intReq      (intReq),
    .spLoad      (spLoad),
    .spLoadEn    (spLoadEn),
    .stackPtr    (stackPtr),
    .stackAddr   (stackAddr),
    .stackWrite  (stackWrite),
    .stackRead   (stackRead),
    .frameByte   (frameByte),
    .frameBusy   (frameBusy),
    .resetPend   (resetPend),
    .serTxPend   (serTxPend),
    .serRxPend   (serRxPend),
    .tmr2OvfPend (tmr2OvfPend),
    .tmr2Ch0Pend (tmr2Ch0Pend),
    .tmr1OvfPend (tmr1OvfPend),
    .vecAddr     (vecAddr),
    .vecValid    (vecValid)
  );
  mmsv_cpu_model u_cpu (
    .sys_clk (sys_clk),
    .go      (go),
    .op      (op),
    .pushReq (pushReq),
    .pullReq (pullReq),
    .callReq (callReq),
    .intReq  (intReq)
  );
  always #50 sys_clk = ~sys_clk;
  task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
    nCompared++;
    if (got !== exp) begin
      errTotal++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wrap_up;
    if (errTotal == 0 && nCompared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic req(logic [2:0] c, int n);
    @(posedge sys_clk) op <= c;
    go <= 1'h1;
    repeat (n) @(posedge sys_clk);
    go <= 1'h0;
  endtask
  task automatic t_stack;
    @(negedge sys_clk) chk("sp reset", stackPtr, 16'h00ff);
    @(posedge sys_clk) spLoad <= 16'h0300;
    spLoadEn <= 1'h1;
    @(posedge sys_clk) spLoadEn <= 1'h0;
    @(negedge sys_clk) chk("sp load", stackPtr, 16'h0300);
    req(3'h1, 2);
    @(negedge sys_clk) chk("push addr", stackAddr, 16'h0300);
    @(negedge sys_clk) chk("push sp", stackPtr, 16'h02fe);
    req(3'h2, 2);
    @(negedge sys_clk) chk("pull addr", stackAddr, 16'h02ff);
    @(negedge sys_clk) chk("pull sp", stackPtr, 16'h0300);
  endtask
  task automatic t_decode;
    logic [15:0] a [12] = '{16'h005f, 16'h0060, 16'h00ff, 16'h0100, 16'h035f,
      16'h0360, 16'hfe0f, 16'hfe10, 16'hfeff, 16'hffd1, 16'hffd2, 16'hffff};
    foreach (a[i]) begin
      @(posedge sys_clk) busAddr <= a[i];
      repeat (2) @(negedge sys_clk);
      chk("ram", selRam, a[i] >= 16'h0060 && a[i] <= 16'h035f);
      chk("zero page", selPageZero, a[i] >= 16'h0060 && a[i] <= 16'h00ff);
      chk("rom", selRom, a[i] >= 16'hfe10 && a[i] <= 16'hfeff);
      chk("vector", selVector, a[i] >= 16'hffd2);
    end
  endtask
  task automatic frame(logic [2:0] c, logic [5:0] m, logic [15:0] v, int nb);
    logic [15:0] sp;
    logic [15:0] q [$];
    int w = 0;
    sp = stackPtr;
    @(posedge sys_clk) {resetPend, tmr1OvfPend, tmr2Ch0Pend} <= m[5:3];
    {tmr2OvfPend, serRxPend, serTxPend} <= m[2:0];
    req(c, 1);
    repeat (14) begin
      @(negedge sys_clk);
      w += stackWrite;
      if (vecValid)
        q.push_back(vecAddr);
    end
    chk("bytes", 16'(w), 16'(nb));
    chk("frame sp", stackPtr, sp - 16'(nb));
    chk("fetches", 16'(q.size()), v != 16'h0000 ? 16'h0002 : 16'h0000);
    if (q.size() == 2) begin
      chk("vec hi", q[0], v);
      chk("vec lo", q[1], v + 16'h0001);
    end
  endtask
  task automatic t_vectors;
    frame(3'h4, 6'h01, 16'hffd2, 5);
    frame(3'h4, 6'h02, 16'hffd4, 5);
    frame(3'h4, 6'h04, 16'hffde, 5);
    frame(3'h4, 6'h08, 16'hffe2, 5);
    frame(3'h4, 6'h10, 16'hffe4, 5);
  endtask
  task automatic t_priority;
    frame(3'h4, 6'h3f, 16'hfffe, 5);
    frame(3'h4, 6'h1c, 16'hffe4, 5);
  endtask
  task automatic t_frames;
    frame(3'h4, 6'h00, 16'h0000, 5);
    frame(3'h3, 6'h00, 16'h0000, 2);
  endtask
  // Reset lands in the middle of an interrupt frame
  task automatic t_reset;
    req(3'h4, 1);
    repeat (3) @(posedge sys_clk);
    rst <= 1'h1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'h0;
    @(negedge sys_clk) chk("sp after reset", stackPtr, 16'h00ff);
    chk("busy after reset", 16'(frameBusy), 16'h0000);
    chk("left after reset", 16'(frameByte), 16'h0000);
    req(3'h1, 1);
    repeat (2) @(negedge sys_clk);
    chk("first push addr", stackAddr, 16'h00ff);
    chk("first push sp", stackPtr, 16'h00fe);
  endtask
  initial begin
    repeat (2000) @(posedge sys_clk);
    errTotal++;
    wrap_up;
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'h0;
    t_stack;
    t_decode;
    t_vectors;
    t_priority;
    t_frames;
    t_reset;
    wrap_up;
  end
endmodule // mmsv_memory_map_tb
`default_nettype wire
